// ### radio_port_pkg.sv
// Shared constants and types for the radio module host port.
`default_nettype none
package radio_port_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int NBAUD = 12;
	// Serial rates in bit/s, selected by index.
	localparam int BAUD_HZ [NBAUD] = '{1200, 2400, 4800, 9600, 14400, 19200,
		28800, 38400, 57600, 115200, 230400, 250000};
	localparam int NSPI = 3;
	// Master SPI rates in kbit/s, index 1 is the typical one.
	localparam int SPI_KBPS [NSPI] = '{125, 250, 500};
	localparam logic [1:0] SPI_RATE_TYP = 2'h1;
	localparam int SPI_SLAVE_MAX_KBPS = 4000;
	localparam int DIV_W = 16;
	localparam int GP_N = 6;
	localparam int WAKE_N = 4;
	localparam int PIN_DAV = 3;
	localparam int PIN_CTS = 4;
	localparam int PIN_RTS = 5;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] SPI_FILL = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_START = 4'b0010,
		S_DATA  = 4'b0100,
		S_STOP  = 4'b1000
	} ser_state_t;
endpackage
`default_nettype wire

// ### radio_host_port.sv
// Host data port, flow control, indicators and general pins of the radio module.
`default_nettype none

// Byte FIFO between the radio side and the host data engines.
module byte_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// Drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_reg [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = cnt_reg != (AW+1)'(D);
	assign out_valid = cnt_reg != '0;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_reg[rd_reg];

	// Pointers and count.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wr_reg <= wr_reg + 1'b1;
			if (pop) rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage needs no reset; the count hides stale words.
	always_ff @(posedge clk) begin
		if (push) mem_reg[wr_reg] <= in_data;
	end
endmodule

// Asynchronous serial transmitter and receiver, 8N1, least significant bit first.
module uart_link (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [15:0] div,
	// Transmit side
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_allow,
	output logic            tx_ready,
	output logic            tx_idle,
	output logic            txd,
	// Receive side, rxd already synchronised
	input  wire logic       rxd,
	output logic [7:0]      rx_data,
	output logic            rx_valid
);
	import radio_port_pkg::*;
	ser_state_t t_st;
	ser_state_t r_st;
	logic [15:0] t_cnt;
	logic [15:0] r_cnt;
	logic [2:0]  t_bit;
	logic [2:0]  r_bit;
	logic [7:0]  t_sh;
	logic [7:0]  r_sh;

	// A byte only starts between frames, so a raised stop line ends after the current byte.
	assign tx_idle  = t_st == S_IDLE;
	assign tx_ready = tx_idle & tx_allow;

	// Transmit sequencer.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			t_st  <= S_IDLE;
			t_cnt <= '0;
			t_bit <= '0;
			t_sh  <= '0;
			txd   <= 1'b1;
		end else if (t_st == S_IDLE) begin
			if (tx_valid & tx_allow) begin
				t_sh  <= tx_data;
				txd   <= 1'b0;
				t_cnt <= '0;
				t_st  <= S_START;
			end
		end else if (t_cnt != div - 16'h1) begin
			t_cnt <= t_cnt + 16'h1;
		end else begin
			t_cnt <= '0;
			case (t_st)
				S_START: begin
					txd   <= t_sh[0];
					t_sh  <= t_sh >> 1;
					t_bit <= '0;
					t_st  <= S_DATA;
				end
				S_DATA: begin
					if (t_bit == LAST_BIT) begin
						txd  <= 1'b1;
						t_st <= S_STOP;
					end else begin
						txd   <= t_sh[0];
						t_sh  <= t_sh >> 1;
						t_bit <= t_bit + 3'h1;
					end
				end
				default: t_st <= S_IDLE;
			endcase
		end
	end

	// Receive sequencer: start bit checked at mid-bit, bits sampled one bit apart.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_st     <= S_IDLE;
			r_cnt    <= '0;
			r_bit    <= '0;
			r_sh     <= '0;
			rx_data  <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			r_cnt    <= r_cnt + 16'h1;
			case (r_st)
				S_IDLE: begin
					r_cnt <= '0;
					if (!rxd) r_st <= S_START;
				end
				S_START: if (r_cnt == (div >> 1)) begin
					r_cnt <= '0;
					r_bit <= '0;
					r_st  <= rxd ? S_IDLE : S_DATA;
				end
				S_DATA: if (r_cnt == div - 16'h1) begin
					r_cnt <= '0;
					r_sh  <= {rxd, r_sh[7:1]};
					r_bit <= r_bit + 3'h1;
					if (r_bit == LAST_BIT) r_st <= S_STOP;
				end
				S_STOP: if (r_cnt == div - 16'h1) begin
					r_st     <= S_IDLE;
					rx_data  <= r_sh;
					rx_valid <= rxd;
				end
				default: r_st <= S_IDLE;
			endcase
		end
	end
endmodule

// Summary of operation
// - Transmit indicator is high while a packet other than a bare acknowledgement is sent.
// - Carrier detect goes low while a valid packet is received.
// - Sending data while receiving acknowledgements asserts both indicators together.
// - Indicator pins can instead carry the maintenance serial output and input.
// - Configuration picks the primary serial port or the SPI port for host data.
// - Clear-to-send is low when a host byte can be taken; host stops when high.
// - Host request line low allows serial output; high stops the module sending.
// - General pins 3, 4, 5 default to plain I/O; alternates are pending and flow lines.
// - In SPI slave mode the pending pin is high while data waits for the master.
// - MISO is input as master and output as slave; MOSI the opposite.
// - Slave select is driven as master and sampled as slave.
// - SPI clock is generated as master and received as slave.
// - Master SPI clock selectable 125, 250 or 500 kbit/s, 250 typical.
// - Both serial ports take a baud rate from the listed set, 1.2 to 250 kbit/s.
// - General inputs have selectable pull-up; outputs have configurable power-on level.
// - Each general pin has a separate sleep direction, pull-up and level.
// - Four general inputs can optionally wake the module from sleep.
module radio_host_port (
	// Clock and reset
	input  wire logic               CLK,
	input  wire logic               RSTN,
	// Configuration
	input  wire logic               MODE_SPI,
	input  wire logic               SPI_MASTER,
	input  wire logic [1:0]         SPI_RATE_SEL,
	input  wire logic [3:0]         BAUD_SEL,
	input  wire logic [3:0]         MAINT_BAUD_SEL,
	input  wire logic               DIAG_ALT,
	input  wire logic               FLOW_ALT,
	input  wire logic               DAV_ALT,
	// Radio activity
	input  wire logic               RF_TX_ACTIVE,
	input  wire logic               RF_TX_ACK_ONLY,
	input  wire logic               RF_RX_VALID,
	// Radio to host stream
	input  wire logic [7:0]         TO_HOST_DATA,
	input  wire logic               TO_HOST_VALID,
	output logic                    TO_HOST_READY,
	// Host to radio stream
	output logic [7:0]              FROM_HOST_DATA,
	output logic                    FROM_HOST_VALID,
	input  wire logic               FROM_HOST_READY,
	// Maintenance serial user side
	input  wire logic [7:0]         MAINT_TX_DATA,
	input  wire logic               MAINT_TX_VALID,
	output logic                    MAINT_TX_READY,
	output logic [7:0]              MAINT_RX_DATA,
	output logic                    MAINT_RX_VALID,
	// General pin control
	input  wire logic               SLEEP,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_DIR,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_PULL,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_INIT,
	input  wire logic               GP_WR,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_WDATA,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_SLP_DIR,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_SLP_PULL,
	input  wire logic [radio_port_pkg::GP_N-1:0] GP_SLP_OUT,
	input  wire logic [radio_port_pkg::WAKE_N-1:0] GP_WAKE_EN,
	output logic [radio_port_pkg::GP_N-1:0] GP_IN,
	output logic [radio_port_pkg::GP_N-1:0] GP_PULL_EN,
	output logic                    WAKE,
	// Pins
	output logic                    PIN2_OUT,
	input  wire logic               PIN3_I,
	output logic                    PIN3_O,
	output logic                    PIN3_OE,
	output logic                    RADIO_TXD,
	input  wire logic               RADIO_RXD,
	input  wire logic               MISO_I,
	output logic                    MISO_O,
	output logic                    MISO_OE,
	input  wire logic               MOSI_I,
	output logic                    MOSI_O,
	output logic                    MOSI_OE,
	input  wire logic               SS_N_I,
	output logic                    SS_N_O,
	output logic                    SS_N_OE,
	input  wire logic               SCLK_I,
	output logic                    SCLK_O,
	output logic                    SCLK_OE,
	input  wire logic [radio_port_pkg::GP_N-1:0] GPIO_I,
	output logic [radio_port_pkg::GP_N-1:0] GPIO_O,
	output logic [radio_port_pkg::GP_N-1:0] GPIO_OE
);
	import radio_port_pkg::*;
	localparam int SN = 6 + GP_N;
	// Idle pin levels for the synchroniser: everything high except the mode 0 SPI clock.
	localparam logic [SN-1:0] SYNC_IDLE = {6'h3e, {GP_N{1'b1}}};

	// Clamp an out-of-range rate select to the fastest entry.
	function automatic logic [3:0] baud_idx(input logic [3:0] s);
		baud_idx = (s < 4'(NBAUD)) ? s : 4'(NBAUD - 1);
	endfunction

	logic [15:0] div_tab [NBAUD];
	logic [15:0] half_tab [NSPI];
	logic [SN-1:0] s1_reg;
	logic [SN-1:0] s2_reg;
	logic rxd_s, p3_s, miso_s, mosi_s, ss_s, sclk_s;
	logic [GP_N-1:0] gp_s;
	logic ti_reg, cd_n_reg, hold_v_reg, init_reg, wake_reg;
	logic [7:0] hold_reg;
	logic [GP_N-1:0] lvl_reg, gp_prev_reg;
	logic [7:0] f_data;
	logic f_valid, f_ready, u_ready, u_idle, u_txd, u_rv;
	logic m_txd;
	logic [7:0] u_rd;
	logic rts_n_eff, slave;
	logic [15:0] spi_half;
	logic [15:0] spi_cnt;
	logic [7:0] spi_sh;
	logic [3:0] spi_bits;
	logic spi_busy, sclk_reg, ss_n_reg, in_bit, sclk_prev, ss_prev, spi_take, spi_done;
	logic [GP_N-1:0] dir_eff, out_eff;

	// Divisor tables follow the clock rate, so retiming CLK_HZ rescales all rates.
	for (genvar i = 0; i < NBAUD; i++) begin : g_baud
		assign div_tab[i] = 16'(CLK_HZ / BAUD_HZ[i]);
	end
	for (genvar i = 0; i < NSPI; i++) begin : g_spi
		assign half_tab[i] = 16'(CLK_HZ / (2000 * SPI_KBPS[i]));
	end
	assign spi_half = half_tab[(SPI_RATE_SEL < 2'(NSPI)) ? SPI_RATE_SEL : SPI_RATE_TYP];

	// Every pin input passes two flops; only the second stage is read.
	// Reset to idle levels, so the clock edge detector sees no false fall after reset.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s1_reg <= SYNC_IDLE;
			s2_reg <= SYNC_IDLE;
		end else begin
			s1_reg <= {RADIO_RXD, PIN3_I, MISO_I, MOSI_I, SS_N_I, SCLK_I, GPIO_I};
			s2_reg <= s1_reg;
		end
	end
	assign {rxd_s, p3_s, miso_s, mosi_s, ss_s, sclk_s, gp_s} = s2_reg;
	assign GP_IN = gp_s;

	// Activity indicators; both may be asserted together.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ti_reg   <= 1'b0;
			cd_n_reg <= 1'b1;
		end else begin
			ti_reg   <= RF_TX_ACTIVE & ~RF_TX_ACK_ONLY;
			cd_n_reg <= ~RF_RX_VALID;
		end
	end

	// Indicator pins or maintenance serial port.
	assign PIN2_OUT = DIAG_ALT ? m_txd : ti_reg;
	assign PIN3_O   = cd_n_reg;
	assign PIN3_OE  = ~DIAG_ALT;

	byte_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk       (CLK),
		.rstn      (RSTN),
		.in_data   (TO_HOST_DATA),
		.in_valid  (TO_HOST_VALID),
		.in_ready  (TO_HOST_READY),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	// Request line only acts in its alternate role; otherwise sending is always allowed.
	assign rts_n_eff = FLOW_ALT & gp_s[PIN_RTS];
	// Only the selected engine drains the FIFO.
	assign f_ready   = MODE_SPI ? spi_take : u_ready;

	uart_link u_pri (
		.clk      (CLK),
		.rstn     (RSTN),
		.div      (div_tab[baud_idx(BAUD_SEL)]),
		.tx_data  (f_data),
		.tx_valid (f_valid & ~MODE_SPI),
		.tx_allow (~rts_n_eff),
		.tx_ready (u_ready),
		.tx_idle  (u_idle),
		.txd      (u_txd),
		.rxd      (rxd_s),
		.rx_data  (u_rd),
		.rx_valid (u_rv)
	);
	assign RADIO_TXD = u_txd;

	uart_link u_maint (
		.clk      (CLK),
		.rstn     (RSTN),
		.div      (div_tab[baud_idx(MAINT_BAUD_SEL)]),
		.tx_data  (MAINT_TX_DATA),
		.tx_valid (MAINT_TX_VALID),
		.tx_allow (DIAG_ALT),
		.tx_ready (MAINT_TX_READY),
		.tx_idle  (),
		.txd      (m_txd),
		.rxd      (p3_s | ~DIAG_ALT),
		.rx_data  (MAINT_RX_DATA),
		.rx_valid (MAINT_RX_VALID)
	);

	// Host byte hold; a new byte wins over a same-cycle take. A byte sent against
	// a raised clear-to-send while the hold is full is lost.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hold_v_reg <= 1'b0;
			hold_reg   <= '0;
		end else if ((MODE_SPI ? spi_done : u_rv) && (!hold_v_reg || FROM_HOST_READY)) begin
			hold_v_reg <= 1'b1;
			hold_reg   <= MODE_SPI ? {spi_sh[6:0], in_bit} : u_rd;
		end else if (FROM_HOST_READY) begin
			hold_v_reg <= 1'b0;
		end
	end
	assign FROM_HOST_DATA  = hold_reg;
	assign FROM_HOST_VALID = hold_v_reg;

	// SPI engine, mode 0, MSB first: capture on rising edge, shift on falling.
	assign slave    = MODE_SPI & ~SPI_MASTER;
	assign spi_take = MODE_SPI & (SPI_MASTER ? (~spi_busy & ~hold_v_reg) :
		(ss_prev & ~ss_s) | (spi_done & ~ss_s)) & f_valid;
	assign spi_done = MODE_SPI & spi_bits == 4'h7 & (SPI_MASTER ?
		(spi_busy & sclk_reg & spi_cnt == spi_half - 16'h1) : (sclk_prev & ~sclk_s & ~ss_s));
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			spi_busy <= 1'b0; spi_cnt <= '0; spi_sh <= '0; spi_bits <= '0;
			sclk_reg <= 1'b0; ss_n_reg <= 1'b1; in_bit <= 1'b0;
			sclk_prev <= 1'b0; ss_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_s;
			ss_prev   <= ss_s;
			if (!MODE_SPI) begin
				spi_busy <= 1'b0; ss_n_reg <= 1'b1; sclk_reg <= 1'b0; spi_bits <= '0;
			end else if (SPI_MASTER) begin
				// Master waits on clear-to-send so its own reply byte has room.
				if (!spi_busy) begin
					spi_cnt <= '0;
					if (spi_take) begin
						spi_sh <= f_data; spi_busy <= 1'b1; ss_n_reg <= 1'b0; spi_bits <= '0;
					end
				end else if (spi_cnt != spi_half - 16'h1) begin
					spi_cnt <= spi_cnt + 16'h1;
				end else begin
					spi_cnt  <= '0;
					sclk_reg <= ~sclk_reg;
					if (!sclk_reg) in_bit <= miso_s;
					else begin
						spi_sh   <= {spi_sh[6:0], in_bit};
						spi_bits <= spi_bits + 4'h1;
						if (spi_done) begin
							spi_busy <= 1'b0; ss_n_reg <= 1'b1;
						end
					end
				end
			end else if (ss_s) begin
				spi_bits <= '0;
			end else begin
				// Slave follows the sampled clock; the link must be well below CLK/2.
				if (!sclk_prev && sclk_s) in_bit <= mosi_s;
				if (sclk_prev && !sclk_s) begin
					spi_sh   <= {spi_sh[6:0], in_bit};
					spi_bits <= spi_done ? 4'h0 : spi_bits + 4'h1;
				end
				if ((ss_prev && !ss_s) || spi_done) spi_sh <= f_valid ? f_data : SPI_FILL;
			end
		end
	end

	// SPI pin directions by role.
	assign MISO_O  = spi_sh[7];
	assign MISO_OE = slave & ~ss_s;
	assign MOSI_O  = spi_sh[7];
	assign MOSI_OE = MODE_SPI & SPI_MASTER;
	assign SS_N_O  = ss_n_reg;
	assign SS_N_OE = MODE_SPI & SPI_MASTER;
	assign SCLK_O  = sclk_reg;
	assign SCLK_OE = MODE_SPI & SPI_MASTER;

	// Output levels load the power-on value just after reset, then follow writes.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			init_reg <= 1'b0;
			lvl_reg  <= '0;
		end else if (!init_reg) begin
			init_reg <= 1'b1;
			lvl_reg  <= GP_INIT;
		end else if (GP_WR) begin
			lvl_reg <= GP_WDATA;
		end
	end

	// Sleep swaps in its own pin set.
	assign dir_eff    = SLEEP ? GP_SLP_DIR : GP_DIR;
	assign out_eff    = SLEEP ? GP_SLP_OUT : lvl_reg;
	assign GP_PULL_EN = (SLEEP ? GP_SLP_PULL : GP_PULL) & ~dir_eff;

	// Plain I/O unless an alternate role claims the pin.
	for (genvar i = 0; i < GP_N; i++) begin : g_gp
		if (i == PIN_DAV) begin : g_dav
			assign GPIO_O[i]  = (DAV_ALT & slave) ? f_valid : out_eff[i];
			assign GPIO_OE[i] = (DAV_ALT & slave) | dir_eff[i];
		end else if (i == PIN_CTS) begin : g_cts
			assign GPIO_O[i]  = FLOW_ALT ? hold_v_reg : out_eff[i];
			assign GPIO_OE[i] = FLOW_ALT | dir_eff[i];
		end else if (i == PIN_RTS) begin : g_rts
			assign GPIO_O[i]  = out_eff[i];
			assign GPIO_OE[i] = ~FLOW_ALT & dir_eff[i];
		end else begin : g_plain
			assign GPIO_O[i]  = out_eff[i];
			assign GPIO_OE[i] = dir_eff[i];
		end
	end

	// Any level change on an enabled sleeping input gives a one-cycle wake pulse.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gp_prev_reg <= '1;
			wake_reg    <= 1'b0;
		end else begin
			gp_prev_reg <= gp_s;
			wake_reg    <= SLEEP & |((gp_s[WAKE_N-1:0] ^ gp_prev_reg[WAKE_N-1:0])
				& GP_WAKE_EN & ~dir_eff[WAKE_N-1:0]);
		end
	end
	assign WAKE = wake_reg;

	chk_ti_pin: assert property (@(posedge CLK) disable iff (!RSTN)
		(RF_TX_ACTIVE && !RF_TX_ACK_ONLY) ##1 !DIAG_ALT |-> PIN2_OUT)
		else $error("transmit indicator not raised");
	chk_cd_pin: assert property (@(posedge CLK) disable iff (!RSTN)
		(RF_RX_VALID && RF_TX_ACTIVE && !RF_TX_ACK_ONLY) ##1 !DIAG_ALT |-> !PIN3_O && PIN2_OUT)
		else $error("indicators not both asserted");
	chk_alt_diag: assert property (@(posedge CLK) disable iff (!RSTN)
		DIAG_ALT |-> !PIN3_OE && PIN2_OUT == m_txd)
		else $error("maintenance pins not routed");
	chk_cts_full: assert property (@(posedge CLK) disable iff (!RSTN)
		FLOW_ALT && hold_v_reg |-> GPIO_OE[PIN_CTS] && GPIO_O[PIN_CTS])
		else $error("clear-to-send low while hold full");
	chk_rts_stop: assert property (@(posedge CLK) disable iff (!RSTN)
		rts_n_eff && u_idle |=> u_idle)
		else $error("serial byte started against request line");
	chk_port_sel: assert property (@(posedge CLK) disable iff (!RSTN)
		MODE_SPI && u_idle |=> u_idle && RADIO_TXD)
		else $error("serial port active in SPI mode");
	chk_dav_flag: assert property (@(posedge CLK) disable iff (!RSTN)
		DAV_ALT && slave |-> GPIO_OE[PIN_DAV] && GPIO_O[PIN_DAV] == f_valid)
		else $error("pending flag wrong");
	chk_spi_dirs: assert property (@(posedge CLK) disable iff (!RSTN)
		MODE_SPI && SPI_MASTER |-> MOSI_OE && SS_N_OE && SCLK_OE && !MISO_OE)
		else $error("master pin directions wrong");
	chk_spi_rate: assert property (@(posedge CLK) disable iff (!RSTN)
		MODE_SPI && SPI_MASTER && $stable(SPI_RATE_SEL) && $changed(sclk_reg)
		|-> $past(spi_cnt) == spi_half - 16'h1)
		else $error("master clock half period wrong");
	chk_sleep_set: assert property (@(posedge CLK) disable iff (!RSTN)
		SLEEP |-> GPIO_OE[2:0] == GP_SLP_DIR[2:0] && GPIO_O[2:0] == GP_SLP_OUT[2:0])
		else $error("sleep pin set not applied");
	chk_wake_src: assert property (@(posedge CLK) disable iff (!RSTN)
		WAKE |-> $past(SLEEP) && $past(|GP_WAKE_EN))
		else $error("wake without enabled sleeping input");
	cov_uart_rx: cover property (@(posedge CLK) disable iff (!RSTN) u_rv && !MODE_SPI);
	cov_spi_mst: cover property (@(posedge CLK) disable iff (!RSTN) spi_done && SPI_MASTER);
	cov_spi_slv: cover property (@(posedge CLK) disable iff (!RSTN) spi_done && slave);
	cov_wake:    cover property (@(posedge CLK) disable iff (!RSTN) WAKE);
endmodule
`default_nettype wire

// ### host_uart.sv
// Behavioural host controller on the far side of the primary serial port.
`default_nettype none
module host_uart #(
	parameter int BIT_NS = 4000
) (
	// Serial lines and flow control
	input  wire logic      txd_in,
	input  wire logic      cts_n,
	output var logic       rxd_out,
	output var logic       rts_n,
	// Last received byte and byte count
	output var logic [7:0] got,
	output var int         n_got
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle high line, and the module is allowed to send from the start.
	initial begin
		rxd_out = 1'b1;
		rts_n = 1'b0;
		got = 8'h00;
		n_got = 0;
	end

	// Sample mid-bit so that clock drift between the two ends does no harm.
	always begin
		@(negedge txd_in);
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 8; i++) begin
			got[i] = txd_in;
			#BIT_NS;
		end
		n_got++;
	end

	// One 8N1 byte, held back while the module cannot accept it.
	task send(input logic [7:0] d);
		wait (cts_n === 1'b0);
		rxd_out = 1'b0;
		#BIT_NS;
		for (int i = 0; i < 8; i++) begin
			rxd_out = d[i];
			#BIT_NS;
		end
		rxd_out = 1'b1;
		#BIT_NS;
	endtask

	// Request line low lets the module send to us.
	task hold(input logic v);
		rts_n = v;
	endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the radio module host port.
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("ERROR %s expected %h seen %h", n, e, a); end end
module testbench import radio_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, RSTN = 0, MODE_SPI = 0, SPI_MASTER = 0, DIAG_ALT = 0, FLOW_ALT = 0;
	logic DAV_ALT = 0, RF_TX_ACTIVE = 0, RF_TX_ACK_ONLY = 0, RF_RX_VALID = 0, GP_WR = 0;
	logic TO_HOST_VALID = 0, FROM_HOST_READY = 0, MAINT_TX_VALID = 0, SLEEP = 0;
	logic PIN3_I = 1, MISO_I = 0, MOSI_I = 0, SS_N_I = 1, SCLK_I = 0;
	logic [1:0] SPI_RATE_SEL = 2'h1;
	logic [3:0] BAUD_SEL = 4'hb, MAINT_BAUD_SEL = 4'hb, GP_WAKE_EN = 4'h0;
	logic [7:0] TO_HOST_DATA = 8'h00, MAINT_TX_DATA = 8'h00;
	logic [GP_N-1:0] GP_DIR = 6'h00, GP_PULL = 6'h00, GP_INIT = 6'h00, GP_WDATA = 6'h00;
	logic [GP_N-1:0] GP_SLP_DIR = 6'h00, GP_SLP_PULL = 6'h00, GP_SLP_OUT = 6'h00;
	wire logic TO_HOST_READY, FROM_HOST_VALID, MAINT_TX_READY, MAINT_RX_VALID, WAKE;
	wire logic PIN2_OUT, PIN3_O, PIN3_OE, RADIO_TXD, RADIO_RXD, MISO_O, MISO_OE;
	wire logic MOSI_O, MOSI_OE, SS_N_O, SS_N_OE, SCLK_O, SCLK_OE, rts_n;
	wire logic [7:0] FROM_HOST_DATA, MAINT_RX_DATA, got;
	wire logic [GP_N-1:0] GP_IN, GP_PULL_EN, GPIO_I, GPIO_O, GPIO_OE;
	int n_got, failures = 0, comparisons = 0;
	logic [4:0] pin_pat = 5'h15;
	logic [7:0] spi_rx = 8'h00, spi_tx = 8'hc3;
	typedef struct packed {logic tx, ack, rx, act, cd_n;} ind_row_t;
	localparam ind_row_t ROWS [5] = '{5'b10011, 5'b11001, 5'b00100, 5'b10110, 5'b00001};

	// Each pin sees its driver; released pins 0 to 4 read an alternating pattern, pin 5 the host request line.
	assign GPIO_I = (GPIO_O & GPIO_OE) | (~GPIO_OE & {rts_n, pin_pat});

	radio_host_port i_dut (.*);
	host_uart #(.BIT_NS(100 * (CLK_HZ / BAUD_HZ[11]))) i_host (.txd_in(RADIO_TXD),
		.cts_n(GPIO_O[4]), .rxd_out(RADIO_RXD), .rts_n(rts_n), .got(got), .n_got(n_got));

	// Free-running 10 MHz clock.
	always #50 CLK = ~CLK;

	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask

	// One byte into the radio-to-host queue, offered for one cycle without waiting for room.
	// The idle cycle after it keeps two calls from rewriting valid in one step.
	task push(input logic [7:0] d);
		TO_HOST_DATA = d;
		TO_HOST_VALID = 1'b1;
		@(negedge CLK);
		TO_HOST_VALID = 1'b0;
		@(negedge CLK);
	endtask

	// Bounded wait so a silent port cannot hang the run.
	task wait_n(input int n);
		for (int k = 0; k < 2000 && n_got < n; k++) @(negedge CLK);
		if (n_got < n) failures++;
	endtask

	task conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence: reset, indicator table, then the awkward cases.
	initial begin
		cyc(2);
		`CHK("txd_rst", 1'b1, RADIO_TXD)
		`CHK("cd_rst", 1'b1, PIN3_O)
		`CHK("hold_rst", 1'b0, FROM_HOST_VALID)
		RSTN = 1'b1;
		cyc(2);
		`CHK("gp_oe", 6'h00, GPIO_OE)
		FLOW_ALT = 1'b1;
		cyc(1);
		`CHK("cts_oe", 1'b1, GPIO_OE[4])
		foreach (ROWS[i]) begin
			{RF_TX_ACTIVE, RF_TX_ACK_ONLY, RF_RX_VALID} = ROWS[i][4:2];
			cyc(3);
			`CHK("act", ROWS[i].act, PIN2_OUT)
			`CHK("cd_n", ROWS[i].cd_n, PIN3_O)
		end
		i_host.hold(1'b1);
		// The request line needs its two synchroniser flops before bytes queue up.
		cyc(3);
		push(8'ha5);
		push(8'h3c);
		cyc(500);
		`CHK("rts_stop", 0, n_got)
		`CHK("txd_idle", 1'b1, RADIO_TXD)
		i_host.hold(1'b0);
		wait_n(1);
		`CHK("tx_first", 8'ha5, got)
		wait_n(2);
		`CHK("tx_second", 8'h3c, got)
		i_host.send(8'h96);
		cyc(2);
		`CHK("rx_data", 8'h96, FROM_HOST_DATA)
		`CHK("rx_valid", 1'b1, FROM_HOST_VALID)
		`CHK("cts_busy", 1'b1, GPIO_O[4])
		FROM_HOST_READY = 1'b1;
		cyc(1);
		FROM_HOST_READY = 1'b0;
		cyc(3);
		`CHK("cts_free", 1'b0, GPIO_O[4])
		MODE_SPI = 1'b1;
		for (int m = 1; m >= 0; m--) begin
			SPI_MASTER = m[0];
			SS_N_I = m[0];
			cyc(3);
			`CHK("miso_oe", ~m[0], MISO_OE)
			`CHK("mosi_oe", m[0], MOSI_OE)
			`CHK("ss_oe", m[0], SS_N_OE)
			`CHK("sclk_oe", m[0], SCLK_OE)
		end
		SS_N_I = 1'b1;
		DAV_ALT = 1'b1;
		push(8'h5a);
		cyc(2);
		`CHK("pending", 1'b1, GPIO_O[3])
		`CHK("pending_oe", 1'b1, GPIO_OE[3])
		// Slave exchange with an 800 ns link clock, far below the slave rate ceiling.
		SS_N_I = 1'b0;
		cyc(4);
		for (int i = 7; i >= 0; i--) begin
			MOSI_I = spi_tx[i];
			cyc(4);
			SCLK_I = 1'b1;
			spi_rx[i] = MISO_O;
			cyc(4);
			SCLK_I = 1'b0;
		end
		cyc(4);
		SS_N_I = 1'b1;
		`CHK("slv_miso", 8'h5a, spi_rx)
		`CHK("slv_mosi", 8'hc3, FROM_HOST_DATA)
		`CHK("slv_valid", 1'b1, FROM_HOST_VALID)
		`CHK("pend_clr", 1'b0, GPIO_O[3])
		// A level change on an enabled sleeping input gives one wake pulse.
		SLEEP = 1'b1;
		GP_WAKE_EN = 4'h1;
		cyc(2);
		pin_pat[0] = 1'b0;
		cyc(3);
		`CHK("wake", 1'b1, WAKE)
		cyc(1);
		`CHK("wake_end", 1'b0, WAKE)
		SLEEP = 1'b0;
		DIAG_ALT = 1'b1;
		cyc(1);
		`CHK("maint_rdy", 1'b1, MAINT_TX_READY)
		`CHK("maint_idle", 1'b1, PIN2_OUT)
		// Reset in mid-run clears the queue and the host byte hold.
		push(8'h11);
		RSTN = 1'b0;
		cyc(1);
		`CHK("hold_mid", 1'b0, FROM_HOST_VALID)
		`CHK("pend_mid", 1'b0, GPIO_O[3])
		RSTN = 1'b1;
		cyc(2);
		`CHK("pend_after", 1'b0, GPIO_O[3])
		conclude();
	end

	// The whole run needs about 0.2 ms; a hang is cut off well after that.
	initial begin
		#2ms;
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
